// >>> rtl/pwmas_deadband.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------
// Dead-band delay of one output: delays the inactive to active edge.
// ----------------------------------------------------------------------
module pwmas_deadband #(
  parameter int CW = 7
) (
  input wire logic clk,
  input wire logic rst_sync_n,
  input wire logic delay_en,
  input wire logic [CW-1:0] delay_cnt,
  input wire logic active_in,
  output logic active_out
);

  // Counter of cycles spent active, saturating at its top.
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  // Registered delayed output.
  logic out_ff;
  logic nxt_out;

  // Counts while the scheduled output is active; restarts when inactive.
  // A delay longer than the active time keeps the output inactive.
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_out = active_in;
    if (!active_in) begin
      nxt_cnt = '0;
    end else if (cnt_ff != {CW{1'b1}}) begin
      nxt_cnt = cnt_ff + 1'b1;
    end
    if (delay_en) begin
      nxt_out = active_in && (cnt_ff >= delay_cnt);
    end
  end

  // Registers of the delay counter and output.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cnt_ff <= '0;
      out_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
    end
  end

  assign active_out = out_ff;

endmodule
`default_nettype wire

// >>> rtl/pwmas_pkg.sv
// ----------------------------------------------------------------------
// Shared constants of the PWM auto-shutdown block.
// ----------------------------------------------------------------------
package pwmas_pkg;

  // Register port widths.
  localparam int REG_AW = 2;
  localparam int DATA_W = 8;

  // Register offsets, one per register.
  localparam logic [REG_AW-1:0] ADDR_DELAY = 2'h0;
  localparam logic [REG_AW-1:0] ADDR_SHUTDOWN = 2'h1;
  localparam logic [REG_AW-1:0] ADDR_AUX = 2'h2;

  // Reset values of the delay and shutdown registers.
  localparam logic [DATA_W-1:0] RST_DELAY = 8'h00;
  localparam logic [DATA_W-1:0] RST_SHUTDOWN = 8'h00;

  // Field positions in the delay and restart register.
  localparam int RSEN_BIT = 7;
  localparam int DC_HI = 6;

  // Field positions in the shutdown control register.
  localparam int STATUS_BIT = 7;
  localparam int SRC_HI = 6;
  localparam int SRC_LO = 4;
  localparam int AC_HI = 3;
  localparam int AC_LO = 2;
  localparam int BD_HI = 1;
  localparam int BD_LO = 0;

  // Bits of the source select field, one per source.
  localparam int SRC_CMP1_BIT = 0;
  localparam int SRC_CMP2_BIT = 1;
  localparam int SRC_FLT_BIT = 2;

  // Bit of a shutdown level field that releases the pair.
  localparam int LVL_TRI_BIT = 1;

  // Bits of the auxiliary status register.
  localparam int PTF_BIT = 0;
  localparam int LIVE_BIT = 1;
  localparam int HOLD_BIT = 2;

  // Bits of the output polarity select, set means active low.
  localparam int POL_AC_BIT = 1;
  localparam int POL_BD_BIT = 0;

  // Input synchroniser layout and its idle value.
  localparam int SYNC_W = 3;
  localparam int IDX_CMP1 = 0;
  localparam int IDX_CMP2 = 1;
  localparam int IDX_FLT = 2;
  localparam logic [SYNC_W-1:0] SYNC_RST = 3'h4;

  // Dead-band count width as the register holds it.
  localparam int DC_W = 7;

endpackage

// >>> rtl/pwmas_top.sv
// Contract
// - Shutdown acts only in enhanced PWM modes.
// - Three-bit field selects comparator and fault sources.
// - Low fault pin is a shutdown event.
// - Selected comparator level triggers shutdown.
// - Pins forced to shutdown levels asynchronously.
// - Pair A/C level: low, high, or released.
// - Pair B/D level uses the same encoding.
// - Event sets status bit; outputs held meanwhile.
// - Auto restart clears status once cause gone.
// - Without auto restart only software clears status.
// - Status set at period start holds period.
// - Outputs resume at the next period start.
// - Status writes ignored while cause is active.
// - Comparator cause keeps status set regardless.
// - Writing one to status forces shutdown.
// - Seven-bit count delays inactive-to-active edge.
// - Two polarity bits choose per-pair active level.
// - Period flag set as second period begins.
// - Dead band only on rising edge, half-bridge.
// - Count above duty keeps output inactive.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module pwmas_top #(
  parameter int DC_W = pwmas_pkg::DC_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [pwmas_pkg::REG_AW-1:0] reg_addr,
  input wire logic [pwmas_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pwmas_pkg::DATA_W-1:0] reg_rdata,
  input wire logic enhanced_mode,
  input wire logic half_bridge_mode,
  input wire logic [1:0] output_polarity_sel,
  input wire logic period_start,
  input wire logic pwm_mod_a,
  input wire logic pwm_mod_b,
  input wire logic pwm_mod_c,
  input wire logic pwm_mod_d,
  input wire logic cmp1_out,
  input wire logic cmp2_out,
  input wire logic fault_input_n,
  output logic pwm_out_a_o,
  output logic pwm_out_a_oe,
  output logic pwm_out_b_o,
  output logic pwm_out_b_oe,
  output logic pwm_out_c_o,
  output logic pwm_out_c_oe,
  output logic pwm_out_d_o,
  output logic pwm_out_d_oe,
  output logic period_timer_flag,
  output logic shutdown_active
);
  import pwmas_pkg::*;

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------

  // The count must fit the seven bits left beside the restart bit.
  if (DC_W < 1 || DC_W > DC_HI + 1) begin : g_bad_dc_w
    $error("DC_W must lie between 1 and 7.");
  end

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Pin level: shutdown level while forced, else active level by polarity.
  function automatic logic pin_level(input logic force_sd, input logic [1:0] lvl,
                                     input logic active, input logic act_low);
    logic v;
    v = active ^ act_low;
    if (force_sd) begin
      v = lvl[0];
    end
    return v;
  endfunction

  // Pin enable: released only when forced with a tri-state level.
  function automatic logic pin_enable(input logic force_sd, input logic [1:0] lvl);
    return !(force_sd && lvl[LVL_TRI_BIT]);
  endfunction

  // Event from the source select and the three condition levels.
  function automatic logic src_event(input logic [2:0] sel, input logic c1,
                                     input logic c2, input logic flt_low);
    return (sel[SRC_CMP1_BIT] && c1) || (sel[SRC_CMP2_BIT] && c2) ||
           (sel[SRC_FLT_BIT] && flt_low);
  endfunction

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------

  // Two-stage release of the asynchronous reset.
  logic [1:0] rst_pipe_ff;
  // Reset used by all other logic.
  logic rst_sync_n;

  // Asserts at once and releases after two clock edges.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_ff <= 2'h0;
    end else begin
      rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_pipe_ff[1];

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------

  // Raw pin vector, three stages and the filtered level.
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  logic [SYNC_W-1:0] sync3_ff;
  logic [SYNC_W-1:0] filt_ff;
  logic [SYNC_W-1:0] nxt_filt;

  assign pin_raw = {fault_input_n, cmp2_out, cmp1_out};

  // A bit changes only once the second and third stages agree.
  always_comb begin
    nxt_filt = filt_ff;
    for (int i = 0; i < SYNC_W; i++) begin
      if (sync2_ff[i] == sync3_ff[i]) begin
        nxt_filt[i] = sync3_ff[i];
      end
    end
  end

  // Synchroniser stages; the first stage feeds only the second.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sync1_ff <= SYNC_RST;
      sync2_ff <= SYNC_RST;
      sync3_ff <= SYNC_RST;
      filt_ff <= SYNC_RST;
    end else begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      filt_ff <= nxt_filt;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------

  // Restart enable and dead-band count.
  logic auto_restart_en_ff;
  logic nxt_auto_restart_en;
  logic [DC_W-1:0] dead_band_count_ff;
  logic [DC_W-1:0] nxt_dead_band_count;
  // Shutdown control fields.
  logic shutdown_status_ff;
  logic nxt_shutdown_status;
  logic [2:0] shutdown_source_sel_ff;
  logic [2:0] nxt_shutdown_source_sel;
  logic [1:0] pair_ac_shutdown_level_ff;
  logic [1:0] nxt_pair_ac_shutdown_level;
  logic [1:0] pair_bd_shutdown_level_ff;
  logic [1:0] nxt_pair_bd_shutdown_level;
  // Period flag and output hold.
  logic period_flag_ff;
  logic nxt_period_flag;
  logic hold_ff;
  logic nxt_hold;
  // Read data register.
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  // Decoded write strobes.
  logic wr_delay;
  logic wr_shutdown;
  logic wr_aux;
  // Synchronised event and the raw asynchronous one.
  logic event_sync;
  logic event_async;

  assign wr_delay = reg_wr && (reg_addr == ADDR_DELAY);
  assign wr_shutdown = reg_wr && (reg_addr == ADDR_SHUTDOWN);
  assign wr_aux = reg_wr && (reg_addr == ADDR_AUX);

  // Event seen by the status logic, from synchronised levels.
  assign event_sync = enhanced_mode && src_event(shutdown_source_sel_ff,
      filt_ff[IDX_CMP1], filt_ff[IDX_CMP2], !filt_ff[IDX_FLT]);

  // Event from the raw pins, used only to force the pins at once.
  assign event_async = enhanced_mode && src_event(shutdown_source_sel_ff,
      cmp1_out, cmp2_out, !fault_input_n);

  // Next values of the configuration fields and the status bit.
  always_comb begin
    nxt_auto_restart_en = auto_restart_en_ff;
    nxt_dead_band_count = dead_band_count_ff;
    nxt_shutdown_source_sel = shutdown_source_sel_ff;
    nxt_pair_ac_shutdown_level = pair_ac_shutdown_level_ff;
    nxt_pair_bd_shutdown_level = pair_bd_shutdown_level_ff;
    nxt_shutdown_status = shutdown_status_ff;
    if (wr_delay) begin
      nxt_auto_restart_en = reg_wdata[RSEN_BIT];
      nxt_dead_band_count = reg_wdata[DC_W-1:0];
    end
    if (wr_shutdown) begin
      nxt_shutdown_source_sel = reg_wdata[SRC_HI:SRC_LO];
      nxt_pair_ac_shutdown_level = reg_wdata[AC_HI:AC_LO];
      nxt_pair_bd_shutdown_level = reg_wdata[BD_HI:BD_LO];
    end
    if (wr_shutdown && !event_sync) begin
      // Software may set or clear only while no cause is present.
      nxt_shutdown_status = reg_wdata[STATUS_BIT];
    end else if (auto_restart_en_ff && !event_sync) begin
      // Automatic restart once the cause has gone.
      nxt_shutdown_status = 1'b0;
    end
    if (event_sync) begin
      // A present cause always wins and keeps the bit set.
      nxt_shutdown_status = 1'b1;
    end
  end

  // Next values of the period flag and the output hold.
  always_comb begin
    nxt_period_flag = period_flag_ff;
    nxt_hold = hold_ff;
    if (wr_aux && reg_wdata[PTF_BIT]) begin
      // Writing one clears the flag.
      nxt_period_flag = 1'b0;
    end
    if (period_start) begin
      // Set wins over a clear in the same cycle.
      nxt_period_flag = 1'b1;
      // Hold for the whole period if the status is set now.
      nxt_hold = shutdown_status_ff;
    end
    if (shutdown_status_ff) begin
      nxt_hold = 1'b1;
    end
  end

  // Read data, valid in the cycle after the read strobe only.
  always_comb begin
    nxt_rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_DELAY: begin
          nxt_rdata[RSEN_BIT] = auto_restart_en_ff;
          nxt_rdata[DC_W-1:0] = dead_band_count_ff;
        end
        ADDR_SHUTDOWN: begin
          nxt_rdata = {shutdown_status_ff, shutdown_source_sel_ff,
                       pair_ac_shutdown_level_ff, pair_bd_shutdown_level_ff};
        end
        ADDR_AUX: begin
          nxt_rdata[PTF_BIT] = period_flag_ff;
          nxt_rdata[LIVE_BIT] = event_sync;
          nxt_rdata[HOLD_BIT] = shutdown_active;
        end
        default: begin
          // Unmapped offsets read as zero.
          nxt_rdata = '0;
        end
      endcase
    end
  end

  // Register state.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      auto_restart_en_ff <= RST_DELAY[RSEN_BIT];
      dead_band_count_ff <= RST_DELAY[DC_W-1:0];
      shutdown_status_ff <= RST_SHUTDOWN[STATUS_BIT];
      shutdown_source_sel_ff <= RST_SHUTDOWN[SRC_HI:SRC_LO];
      pair_ac_shutdown_level_ff <= RST_SHUTDOWN[AC_HI:AC_LO];
      pair_bd_shutdown_level_ff <= RST_SHUTDOWN[BD_HI:BD_LO];
      period_flag_ff <= 1'b0;
      hold_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      auto_restart_en_ff <= nxt_auto_restart_en;
      dead_band_count_ff <= nxt_dead_band_count;
      shutdown_status_ff <= nxt_shutdown_status;
      shutdown_source_sel_ff <= nxt_shutdown_source_sel;
      pair_ac_shutdown_level_ff <= nxt_pair_ac_shutdown_level;
      pair_bd_shutdown_level_ff <= nxt_pair_bd_shutdown_level;
      period_flag_ff <= nxt_period_flag;
      hold_ff <= nxt_hold;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign period_timer_flag = period_flag_ff;

  // ----------------------------------------------------------------------
  // Dead band and output stage
  // ----------------------------------------------------------------------

  // Delayed active levels of the four outputs.
  logic act_a;
  logic act_b;
  logic act_c;
  logic act_d;
  // Dead band is used only in half-bridge mode.
  logic db_en;
  // Shutdown forcing of the pins.
  logic force_sd;

  assign db_en = half_bridge_mode;

  // Output A with its dead band.
  pwmas_deadband #(.CW(DC_W)) u_db_a (
    .clk(clk),
    .rst_sync_n(rst_sync_n),
    .delay_en(db_en),
    .delay_cnt(dead_band_count_ff),
    .active_in(pwm_mod_a),
    .active_out(act_a)
  );

  // Output B with its dead band.
  pwmas_deadband #(.CW(DC_W)) u_db_b (
    .clk(clk),
    .rst_sync_n(rst_sync_n),
    .delay_en(db_en),
    .delay_cnt(dead_band_count_ff),
    .active_in(pwm_mod_b),
    .active_out(act_b)
  );

  // Outputs C and D carry no dead band; a register keeps them aligned.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      act_c <= 1'b0;
      act_d <= 1'b0;
    end else begin
      act_c <= pwm_mod_c;
      act_d <= pwm_mod_d;
    end
  end

  // Held while status or period hold stands, or at once on a raw event.
  assign shutdown_active = enhanced_mode &&
      (event_async || shutdown_status_ff || hold_ff);
  assign force_sd = shutdown_active;

  // Pin levels; the forcing path is combinational so it needs no clock.
  assign pwm_out_a_o = pin_level(force_sd, pair_ac_shutdown_level_ff, act_a,
      output_polarity_sel[POL_AC_BIT]);
  assign pwm_out_c_o = pin_level(force_sd, pair_ac_shutdown_level_ff, act_c,
      output_polarity_sel[POL_AC_BIT]);
  assign pwm_out_b_o = pin_level(force_sd, pair_bd_shutdown_level_ff, act_b,
      output_polarity_sel[POL_BD_BIT]);
  assign pwm_out_d_o = pin_level(force_sd, pair_bd_shutdown_level_ff, act_d,
      output_polarity_sel[POL_BD_BIT]);

  // Pin enables; a pair is released under a tri-state level.
  assign pwm_out_a_oe = pin_enable(force_sd, pair_ac_shutdown_level_ff);
  assign pwm_out_c_oe = pin_enable(force_sd, pair_ac_shutdown_level_ff);
  assign pwm_out_b_oe = pin_enable(force_sd, pair_bd_shutdown_level_ff);
  assign pwm_out_d_oe = pin_enable(force_sd, pair_bd_shutdown_level_ff);

endmodule
`default_nettype wire

// >>> verification/pwmas_bridge_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------
// Bridge drivers and fault sensing at the far side of the pins.
// ----------------------------------------------------------------------
module pwmas_bridge_model (
  input wire logic [3:0] pin_o,
  input wire logic [3:0] pin_oe,
  input wire logic [2:0] fault_req,
  output logic [3:0] pin_lvl,
  output logic cmp1_out,
  output logic cmp2_out,
  output logic fault_input_n
);
  // A released pin falls to the pull-down that keeps its switch off.
  assign pin_lvl = pin_o & pin_oe;
  // Current sensors trip high; the fault line idles high on its pull-up.
  assign cmp1_out = fault_req[0];
  assign cmp2_out = fault_req[1];
  assign fault_input_n = !fault_req[2];
endmodule
`default_nettype wire

// >>> verification/pwmas_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------
// Port-level checks of the PWM auto-shutdown block.
// ----------------------------------------------------------------------
module pwmas_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [pwmas_pkg::REG_AW-1:0] reg_addr,
  input wire logic [pwmas_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [pwmas_pkg::DATA_W-1:0] reg_rdata,
  input wire logic enhanced_mode,
  input wire logic half_bridge_mode,
  input wire logic [1:0] output_polarity_sel,
  input wire logic period_start,
  input wire logic pwm_mod_a,
  input wire logic pwm_mod_c,
  input wire logic cmp1_out,
  input wire logic cmp2_out,
  input wire logic fault_input_n,
  input wire logic pwm_out_a_o,
  input wire logic pwm_out_a_oe,
  input wire logic pwm_out_b_o,
  input wire logic pwm_out_b_oe,
  input wire logic pwm_out_c_o,
  input wire logic pwm_out_c_oe,
  input wire logic period_timer_flag,
  input wire logic shutdown_active
);
  import pwmas_pkg::*;
  logic [6:0] cfg_ff; // Shadow of the source and level fields.
  logic [6:0] nxt_cfg;
  logic dly_ff; // Set while the dead-band count is not zero.
  logic nxt_dly;
  logic ev; // A selected source is live in an enhanced mode.
  // The shadows follow the writes, so the checks know the setup.
  always_comb begin
    nxt_cfg = (reg_wr && reg_addr == ADDR_SHUTDOWN) ? reg_wdata[6:0] : cfg_ff;
    nxt_dly = (reg_wr && reg_addr == ADDR_DELAY) ? |reg_wdata[DC_HI:0] : dly_ff;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= 7'h00;
      dly_ff <= 1'b0;
    end else begin
      cfg_ff <= nxt_cfg;
      dly_ff <= nxt_dly;
    end
  end
  assign ev = enhanced_mode && ((cfg_ff[SRC_LO] && cmp1_out) ||
    (cfg_ff[SRC_LO+1] && cmp2_out) || (cfg_ff[SRC_HI] && !fault_input_n));
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside the read cycle");
  a_read_flag: assert property (reg_rd && reg_addr == ADDR_AUX |=>
    reg_rdata[PTF_BIT] == $past(period_timer_flag) && reg_rdata[7:3] == 5'h00)
    else $error("aux read does not match the period flag");
  a_flag_set: assert property (period_start |=> period_timer_flag)
    else $error("period flag not set after period start");
  a_std_mode: assert property (!enhanced_mode |-> !shutdown_active)
    else $error("pins forced outside enhanced mode");
  a_event_force: assert property (ev |-> shutdown_active)
    else $error("selected source did not force the pins");
  a_level_ac: assert property (shutdown_active |-> (cfg_ff[AC_HI] ?
    !pwm_out_a_oe && !pwm_out_c_oe : pwm_out_a_oe && pwm_out_c_oe &&
    pwm_out_a_o == cfg_ff[AC_LO] && pwm_out_c_o == cfg_ff[AC_LO]))
    else $error("pair A/C not at its shutdown level");
  a_level_bd: assert property (shutdown_active |-> (cfg_ff[BD_HI] ?
    !pwm_out_b_oe : pwm_out_b_oe && pwm_out_b_o == cfg_ff[BD_LO]))
    else $error("pair B/D not at its shutdown level");
  a_resume_edge: assert property ($fell(shutdown_active) && enhanced_mode &&
    $past(enhanced_mode) |-> $past(period_start))
    else $error("pins resumed away from a period start");
  a_out_polarity: assert property (!shutdown_active && !$past(shutdown_active)
    |-> pwm_out_c_oe && pwm_out_c_o == ($past(pwm_mod_c) ^ output_polarity_sel[POL_AC_BIT]))
    else $error("output C level does not follow drive and polarity");
  a_dead_band: assert property ($rose(pwm_mod_a) && half_bridge_mode && dly_ff
    |=> shutdown_active || pwm_out_a_o == output_polarity_sel[POL_AC_BIT])
    else $error("output A went active without dead band");
  c_event: cover property (ev);
  c_resume: cover property ($fell(shutdown_active));
  c_flag: cover property ($rose(period_timer_flag));
endmodule
bind pwmas_top pwmas_properties chk_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .enhanced_mode(enhanced_mode), .half_bridge_mode(half_bridge_mode),
  .output_polarity_sel(output_polarity_sel), .period_start(period_start),
  .pwm_mod_a(pwm_mod_a), .pwm_mod_c(pwm_mod_c), .cmp1_out(cmp1_out), .cmp2_out(cmp2_out),
  .fault_input_n(fault_input_n), .pwm_out_a_o(pwm_out_a_o), .pwm_out_a_oe(pwm_out_a_oe),
  .pwm_out_b_o(pwm_out_b_o), .pwm_out_b_oe(pwm_out_b_oe), .pwm_out_c_o(pwm_out_c_o),
  .pwm_out_c_oe(pwm_out_c_oe), .period_timer_flag(period_timer_flag),
  .shutdown_active(shutdown_active));
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pwmas_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic enh = 1'b1; // Enhanced mode except where the standard mode is probed.
  logic hb = 1'b0;
  logic [1:0] pol = 2'h0;
  logic ps = 1'b0;
  logic [3:0] mod = 4'h0; // Scheduled drive, bit 0 is A up to bit 3 is D.
  logic [2:0] req = 3'h0; // Sensor trips: cmp1, cmp2, fault.
  logic [3:0] po, poe, lvl;
  logic c1, c2, fn, flag, sd;
  int failures = 0;
  int compares = 0;
  always #20 clk = ~clk;
  pwmas_top dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .enhanced_mode(enh),
    .half_bridge_mode(hb), .output_polarity_sel(pol), .period_start(ps),
    .pwm_mod_a(mod[0]), .pwm_mod_b(mod[1]), .pwm_mod_c(mod[2]), .pwm_mod_d(mod[3]),
    .cmp1_out(c1), .cmp2_out(c2), .fault_input_n(fn), .pwm_out_a_o(po[0]),
    .pwm_out_a_oe(poe[0]), .pwm_out_b_o(po[1]), .pwm_out_b_oe(poe[1]),
    .pwm_out_c_o(po[2]), .pwm_out_c_oe(poe[2]), .pwm_out_d_o(po[3]),
    .pwm_out_d_oe(poe[3]), .period_timer_flag(flag), .shutdown_active(sd));
  pwmas_bridge_model bridge_u (.pin_o(po), .pin_oe(poe), .fault_req(req),
    .pin_lvl(lvl), .cmp1_out(c1), .cmp2_out(c2), .fault_input_n(fn));
  // ----------------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------------
  task automatic report_and_stop;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // Read data stand in the cycle after the strobe.
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] e);
    logic [7:0] q;
    rd_reg(a, q);
    chk(q, e);
  endtask
  // Polls the status bit with a bounded number of reads.
  task automatic wait_sts(input logic v);
    logic [7:0] q;
    rd_reg(ADDR_SHUTDOWN, q);
    for (int i = 0; i < 16 && q[STATUS_BIT] !== v; i++) rd_reg(ADDR_SHUTDOWN, q);
    chk({7'h00, q[STATUS_BIT]}, {7'h00, v});
    if (q[STATUS_BIT] !== v) report_and_stop();
  endtask
  task automatic pstart;
    @(posedge clk);
    ps <= 1'b1;
    @(posedge clk);
    ps <= 1'b0;
    #1;
  endtask
  task automatic sense(input logic [2:0] r);
    @(posedge clk);
    req <= r;
    #1;
  endtask
  // ----------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------
  task automatic t_regs;
    for (int a = 0; a < 4; a++) rd_chk(a[1:0], 8'h00);
    wr_reg(ADDR_DELAY, 8'h85);
    rd_chk(ADDR_DELAY, 8'h85);
    wr_reg(2'h3, 8'hff);
    rd_chk(2'h3, 8'h00);
    wr_reg(ADDR_DELAY, 8'h00);
  endtask
  task automatic t_flag;
    pstart();
    chk({7'h00, flag}, 8'h01);
    rd_chk(ADDR_AUX, 8'h01);
    wr_reg(ADDR_AUX, 8'h01);
    rd_chk(ADDR_AUX, 8'h00);
  endtask
  task automatic t_fault;
    wr_reg(ADDR_SHUTDOWN, 8'h46);
    sense(3'b100);
    chk({poe, lvl}, 8'h55);
    wait_sts(1'b1);
    rd_chk(ADDR_AUX, 8'h06);
    wr_reg(ADDR_SHUTDOWN, 8'h46);
    rd_chk(ADDR_SHUTDOWN, 8'hc6);
    pstart();
    chk({7'h00, sd}, 8'h01);
    sense(3'b000);
    repeat (8) @(posedge clk);
    rd_chk(ADDR_SHUTDOWN, 8'hc6);
    wr_reg(ADDR_SHUTDOWN, 8'h46);
    rd_chk(ADDR_SHUTDOWN, 8'h46);
    chk({7'h00, sd}, 8'h01);
    pstart();
    chk({7'h00, sd}, 8'h00);
  endtask
  task automatic t_cmp_auto;
    wr_reg(ADDR_DELAY, 8'h80);
    wr_reg(ADDR_SHUTDOWN, 8'h31);
    sense(3'b010);
    chk({poe, lvl}, 8'hfa);
    wait_sts(1'b1);
    wr_reg(ADDR_SHUTDOWN, 8'h31);
    rd_chk(ADDR_SHUTDOWN, 8'hb1);
    sense(3'b000);
    wait_sts(1'b0);
    chk({7'h00, sd}, 8'h01);
    pstart();
    chk({7'h00, sd}, 8'h00);
    wr_reg(ADDR_DELAY, 8'h00);
  endtask
  task automatic t_soft;
    wr_reg(ADDR_SHUTDOWN, 8'h80);
    chk({7'h00, sd}, 8'h01);
    rd_chk(ADDR_SHUTDOWN, 8'h80);
    wr_reg(ADDR_SHUTDOWN, 8'h00);
    pstart();
    chk({7'h00, sd}, 8'h00);
  endtask
  // Each sensor trips for a moment between edges, so no status is left.
  task automatic t_sources;
    for (int s = 0; s < 8; s++) begin
      wr_reg(ADDR_SHUTDOWN, {1'b0, s[2:0], 4'hc});
      for (int k = 0; k < 3; k++) begin
        @(negedge clk);
        req = 3'b001 << k;
        #1 chk({7'h00, sd}, {7'h00, s[k]});
        req = 3'b000;
      end
    end
    @(posedge clk);
    enh <= 1'b0;
    @(negedge clk);
    req = 3'b111;
    #1 chk({7'h00, sd}, 8'h00);
    req = 3'b000;
    @(posedge clk);
    enh <= 1'b1;
    wr_reg(ADDR_SHUTDOWN, 8'h00);
  endtask
  task automatic t_polarity;
    for (int p = 0; p < 4; p++) begin
      @(posedge clk);
      pol <= p[1:0];
      mod <= 4'hf;
      repeat (2) @(posedge clk);
      #1 chk({4'h0, po}, {4'h0, ~p[0], ~p[1], ~p[0], ~p[1]});
    end
    @(posedge clk);
    pol <= 2'h0;
    mod <= 4'h0;
  endtask
  task automatic t_dead;
    int n;
    wr_reg(ADDR_DELAY, 8'h03);
    @(posedge clk);
    hb <= 1'b1;
    mod <= 4'h1;
    n = 0;
    for (int i = 0; i < 20 && po[0] !== 1'b1; i++) begin
      @(posedge clk);
      #1 n++;
    end
    chk(n[7:0], 8'h04);
    if (n == 20) report_and_stop();
    @(posedge clk);
    mod <= 4'h0;
    @(posedge clk);
    #1 chk({7'h00, po[0]}, 8'h00);
    @(posedge clk);
    mod <= 4'h1;
    repeat (3) @(posedge clk);
    mod <= 4'h0;
    n = 0;
    repeat (6) begin
      @(posedge clk);
      #1 n += po[0];
    end
    chk(n[7:0], 8'h00);
    hb <= 1'b0;
    wr_reg(ADDR_DELAY, 8'h00);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_flag();
    t_fault();
    t_cmp_auto();
    t_soft();
    t_sources();
    t_polarity();
    t_dead();
    report_and_stop();
  end
endmodule
`default_nettype wire
